// [hw/tdc_pkg.sv]
// constants, tables and carrier types for the triple block cipher engine
`default_nettype none
package tdc_pkg;

   localparam int BLK_W  = 64;
   localparam int HALF_W = 32;
   localparam int CD_W   = 28;
   localparam int SUB_W  = 48;

   // 3 stages of 16 rounds, one round per enabled clock
   localparam logic [5:0] LAST_ROUND  = 6'h2F;
   localparam logic [3:0] STAGE_LAST  = 4'hF;
   localparam logic [1:0] STAGE_MID   = 2'h1;
   localparam logic [1:0] STAGE_FIRST = 2'h0;
   localparam int         CALC_CYCLES = 48;

   // cumulative key rotation before each round
   localparam int CUM_SHIFT [16] = '{1, 2, 4, 6, 8, 10, 12, 14, 15, 17, 19, 21, 23, 25, 27, 28};

   localparam int P_TBL [32] = '{16, 7, 20, 21, 29, 12, 28, 17, 1, 15, 23, 26, 5, 18, 31, 10,
                                 2, 8, 24, 14, 32, 27, 3, 9, 19, 13, 30, 6, 22, 11, 4, 25};

   localparam int PC1_TBL [56] = '{57, 49, 41, 33, 25, 17, 9, 1, 58, 50, 42, 34, 26, 18,
                                   10, 2, 59, 51, 43, 35, 27, 19, 11, 3, 60, 52, 44, 36,
                                   63, 55, 47, 39, 31, 23, 15, 7, 62, 54, 46, 38, 30, 22,
                                   14, 6, 61, 53, 45, 37, 29, 21, 13, 5, 28, 20, 12, 4};

   localparam int PC2_TBL [48] = '{14, 17, 11, 24, 1, 5, 3, 28, 15, 6, 21, 10,
                                   23, 19, 12, 4, 26, 8, 16, 7, 27, 20, 13, 2,
                                   41, 52, 31, 37, 47, 55, 30, 40, 51, 45, 33, 48,
                                   44, 49, 39, 56, 34, 53, 46, 42, 50, 36, 29, 32};

   // substitution boxes, entry 0 in the top nibble, index = row * 16 + column
   localparam logic [255:0] SBOX [8] = '{
      256'hE4D1_2FB8_3A6C_5907_0F74_E2D1_A6CB_9538_41E8_D62B_FC97_3A50_FC82_4917_5B3E_A06D,
      256'hF18E_6B34_972D_C05A_3D47_F28E_C01A_69B5_0E7B_A4D1_58C6_932F_D8A1_3F42_B67C_05E9,
      256'hA09E_63F5_1DC7_B428_D709_346A_285E_CBF1_D649_8F30_B12C_5AE7_1AD0_6987_4FE3_B52C,
      256'h7DE3_069A_1285_BC4F_D8B5_6F03_472C_1AE9_A690_CB7D_F13E_5284_3F06_A1D8_945B_C72E,
      256'h2C41_7AB6_853F_D0E9_EB2C_47D1_50FA_3986_421B_AD78_F9C5_630E_B8C7_1E2D_6F09_A453,
      256'hC1AF_9268_0D34_E75B_AF42_7C95_61DE_0B38_9EF5_28C3_704A_1DB6_432C_95FA_BE17_608D,
      256'h4B2E_F08D_3C97_5A61_D0B7_491A_E35C_2F86_14BD_C37E_AF68_0592_6BD8_14A7_950F_E23C,
      256'hD284_6FB1_A93E_50C7_1FD8_A374_C56B_0E92_7B41_9CE2_06AD_F358_21E7_4A8D_FC90_356B};

   typedef struct packed {
      logic [63:0] k1;
      logic [63:0] k2;
      logic [63:0] k3;
   } tdc_keys_t;

   typedef struct packed {
      logic decrypt;
      logic two_key;
   } tdc_mode_t;

endpackage : tdc_pkg
`default_nettype wire

// [hw/tdc_triple_cipher.sv]
// triple block algorithm engine: ede over three single-cipher stages
// Functional notes
// R1 - three independent keys drive the three single-cipher stages when two-key mode is off.
// R2 - in two-key mode the first key is reused for the third stage.
// R3 - software loads every key (56 effective bits each, parity ignored) before starting.
// R4 - encryption turns one loaded 8-byte block into 8 ciphertext bytes held for reading.
// R5 - decryption turns one loaded 8-byte block into 8 plaintext bytes held for reading.
// R6 - a calculation always takes the same number of cycles whatever key or data.
// R7 - start begins a calculation, busy stands until the result is valid, done then rises,
//      and key or data loads while busy are ignored.
`timescale 1ns/1ps
`default_nettype none
module tdc_triple_cipher
   import tdc_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic              ce,
   // loading
   input  wire logic              key_load,
   input  wire tdc_keys_t         keys_in,
   input  wire logic              data_load,
   input  wire logic [BLK_W-1:0]  data_in,
   // control
   input  wire logic              start,
   input  wire tdc_mode_t         mode_in,
   // status and result
   output var  logic              busy,
   output var  logic              done,
   output var  logic [BLK_W-1:0]  result
);

   function automatic logic [63:0] perm_ip(input logic [63:0] x);
      logic [63:0] y;
      int          src;
      y = '0;
      for (int i = 0; i < 64; i++)
      begin
         src = (((i / 8) < 4) ? (58 + 2 * (i / 8)) : (57 + 2 * (i / 8 - 4))) - 8 * (i % 8);
         y[63-i] = x[64-src];
      end
      return y;
   endfunction : perm_ip

   function automatic logic [63:0] perm_fp(input logic [63:0] x);
      logic [63:0] y;
      int          src;
      y = '0;
      for (int i = 0; i < 64; i++)
      begin
         src = (((i / 8) < 4) ? (58 + 2 * (i / 8)) : (57 + 2 * (i / 8 - 4))) - 8 * (i % 8);
         y[64-src] = x[63-i];
      end
      return y;
   endfunction : perm_fp

   function automatic logic [27:0] rotl28(input logic [27:0] x, input int n);
      logic [55:0] t;
      t = {x, x} << n;
      return t[55:28];
   endfunction : rotl28

   // round function: expand, mix key, substitute, permute
   function automatic logic [31:0] feistel(input logic [31:0] r, input logic [47:0] k);
      logic [47:0] e;
      logic [31:0] s;
      logic [31:0] p;
      logic [5:0]  b;
      logic [5:0]  idx;
      e = '0;
      s = '0;
      p = '0;
      b = '0;
      idx = '0;
      for (int i = 0; i < 48; i++)
         e[47-i] = r[31-((4 * (i / 6) + (i % 6) + 31) % 32)];
      e = e ^ k;
      for (int j = 0; j < 8; j++)
      begin
         b = e[47-6*j -: 6];
         idx = {b[5], b[0], b[4:1]};
         s[31-4*j -: 4] = SBOX[j][255-4*idx -: 4];
      end
      for (int i = 0; i < 32; i++)
         p[31-i] = s[32-P_TBL[i]];
      return p;
   endfunction : feistel

   tdc_keys_t          key_reg;
   logic [BLK_W-1:0]   data_reg;
   tdc_mode_t          mode_reg;
   logic [HALF_W-1:0]  l_reg;
   logic [HALF_W-1:0]  r_reg;
   logic [5:0]         rnd_reg;
   logic               busy_reg;
   logic               done_reg;
   logic [BLK_W-1:0]   result_reg;

   logic               accept;
   logic               finish;
   logic [1:0]         stage;
   logic [3:0]         rsub;
   logic               dec_stage;
   logic [63:0]        stage_key;
   logic [55:0]        cd;
   logic [3:0]         kstep;
   logic [SUB_W-1:0]   subkey;
   logic [HALF_W-1:0]  fout;
   logic [BLK_W-1:0]   ip_out;

   assign accept = ce && start && !busy_reg;                     // [R7]
   assign finish = ce && busy_reg && (rnd_reg == LAST_ROUND);
   assign stage  = rnd_reg[5:4];
   assign rsub   = rnd_reg[3:0];
   assign ip_out = perm_ip(data_reg);

   // stage key and direction: ede for encryption, ded with keys reversed for decryption
   always_comb
   begin
      logic [55:0] rot;
      rot = '0;
      dec_stage = (stage == STAGE_MID) ^ mode_reg.decrypt;      // [R4] [R5]
      unique case (stage)
         STAGE_FIRST: stage_key = mode_reg.decrypt
                                  ? (mode_reg.two_key ? key_reg.k1 : key_reg.k3)  // [R1] [R2]
                                  : key_reg.k1;
         STAGE_MID:   stage_key = key_reg.k2;
         default:     stage_key = mode_reg.decrypt ? key_reg.k1
                                  : (mode_reg.two_key ? key_reg.k1 : key_reg.k3); // [R1] [R2]
      endcase
      cd = '0;
      for (int i = 0; i < 56; i++)
         cd[55-i] = stage_key[64-PC1_TBL[i]];                    // parity bits dropped [R3]
      // decryption walks the schedule backwards instead of rotating right
      kstep = dec_stage ? (STAGE_LAST - rsub) : rsub;
      rot = {rotl28(cd[55:28], CUM_SHIFT[kstep]), rotl28(cd[27:0], CUM_SHIFT[kstep])};
      subkey = '0;
      for (int i = 0; i < 48; i++)
         subkey[47-i] = rot[56-PC2_TBL[i]];
   end

   assign fout = feistel(r_reg, subkey);

   // key and block holding; writes while busy are dropped
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         key_reg <= '0;
      else if (ce && key_load && !busy_reg)                       // [R7] [R3]
         key_reg <= keys_in;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         data_reg <= '0;
      else if (ce && data_load && !busy_reg)                      // [R7]
         data_reg <= data_in;
   end

   // round engine: fixed 48 rounds, no data-dependent exits
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         l_reg    <= '0;
         r_reg    <= '0;
         rnd_reg  <= '0;
         busy_reg <= 1'b0;
         mode_reg <= '0;
      end
      else if (accept)
      begin
         l_reg    <= ip_out[63:32];
         r_reg    <= ip_out[31:0];
         rnd_reg  <= '0;
         busy_reg <= 1'b1;
         mode_reg <= mode_in;
      end
      else if (ce && busy_reg)
      begin
         // the unswapped last round of each stage stands in for fp then ip between stages
         if (rsub == STAGE_LAST)
            l_reg <= l_reg ^ fout;
         else
         begin
            l_reg <= r_reg;
            r_reg <= l_reg ^ fout;
         end
         rnd_reg <= rnd_reg + 6'h01;
         if (rnd_reg == LAST_ROUND)                                // [R6]
            busy_reg <= 1'b0;
      end
   end

   // result and completion flag; the flag clears when the next calculation starts
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         result_reg <= '0;
         done_reg   <= 1'b0;
      end
      else if (finish)
      begin
         result_reg <= perm_fp({l_reg ^ fout, r_reg});            // [R4] [R5]
         done_reg   <= 1'b1;                                      // [R7]
      end
      else if (accept)
         done_reg <= 1'b0;
   end

   assign busy   = busy_reg;
   assign done   = done_reg;
   assign result = result_reg;

   // ce stalls stretch time, so the checks below stand down while it is low
   // the flags change at the 48th edge after the start, so they are seen one edge later
   calc_latency_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R6]
      accept |-> ##49 (!busy_reg && done_reg))
      else $error("calculation did not finish in 48 cycles");

   calc_busy_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R7]
      accept |=> busy_reg[*8] ##39 busy_reg)
      else $error("busy dropped early");

   done_on_fall_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R7]
      $fell(busy_reg) |-> done_reg && $changed(rnd_reg))
      else $error("busy fell without completion");

   key_lock_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R7]
      (busy_reg && key_load) |=> $stable(key_reg))
      else $error("key changed while busy");

   data_lock_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R7]
      (busy_reg && data_load) |=> $stable(data_reg))
      else $error("data changed while busy");

   result_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R4]
      (done_reg && !finish) |=> $stable(result_reg))
      else $error("result moved while held");

   two_key_use_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R2]
      (busy_reg && mode_reg.two_key && stage != STAGE_MID) |-> stage_key == key_reg.k1)
      else $error("two-key mode used a third key");

   three_key_use_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R1]
      (busy_reg && !mode_reg.two_key && !mode_reg.decrypt && stage == 2'h2)
         |-> stage_key == key_reg.k3)
      else $error("third stage did not use third key");

   stage_dir_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R5]
      (busy_reg && stage == STAGE_MID) |-> dec_stage == !mode_reg.decrypt)
      else $error("middle stage ran in the wrong direction");

   start_ignored_a: assert property (@(posedge ref_clk) disable iff (!resetn || !ce) // [R7]
      (busy_reg && start && rnd_reg != LAST_ROUND) |=> busy_reg && rnd_reg == $past(rnd_reg) + 6'h01)
      else $error("start restarted a running calculation");

   enc_done_c: cover property (@(posedge ref_clk) finish && !mode_reg.decrypt);
   dec_done_c: cover property (@(posedge ref_clk) finish && mode_reg.decrypt);
   two_key_c:  cover property (@(posedge ref_clk) finish && mode_reg.two_key);
   key_drop_c: cover property (@(posedge ref_clk) ce && busy_reg && key_load);

endmodule : tdc_triple_cipher
`default_nettype wire

// [sim/tdc_tb.sv]
// self-checking bench for the triple block cipher engine
`timescale 1ns/1ps
`default_nettype none
module tb
   import tdc_pkg::*;
;
   // single-cipher known answers; equal keys collapse the triple run to one stage
   localparam logic [63:0] KA = 64'h1334_5779_9BBC_DFF1;
   localparam logic [63:0] KB = 64'h0123_4567_89AB_CDEF;
   localparam logic [63:0] KZ = 64'h0E32_9232_EA6D_0D73;
   localparam logic [63:0] KP = 64'h0101_0101_0101_0101;
   localparam logic [63:0] PT = 64'h0123_4567_89AB_CDEF;
   localparam logic [63:0] CT = 64'h85E8_1354_0F0A_B405;
   localparam logic [63:0] PZ = 64'h8787_8787_8787_8787;

   typedef struct packed {
      tdc_keys_t   k;
      logic [1:0]  m;
      logic [63:0] d;
      logic [63:0] exp;
   } tdc_row_t;

   // keys that cancel out (kb then kb inverse) leave only the stage under test
   tdc_row_t rows [10] = '{
      '{{KA, KA, KA}, 2'h0, PT, CT}, '{{KA, KA, KA}, 2'h2, CT, PT},
      '{{KB, KB, KA}, 2'h0, PT, CT}, '{{KA, KB, KB}, 2'h0, PT, CT},
      '{{KB, KB, KA}, 2'h2, CT, PT}, '{{KA, KA, KB}, 2'h1, PT, CT},
      '{{KA, KA, KB}, 2'h3, CT, PT}, '{{KA ^ KP, KA, KA ^ KP}, 2'h0, PT, CT},
      '{{KZ, KZ, KZ}, 2'h0, PZ, 64'h0000_0000_0000_0000},
      '{{KZ, KZ, KA}, 2'h1, PZ, 64'h0000_0000_0000_0000}};

   logic              ref_clk   = 1'b0;
   logic              resetn    = 1'b0;
   logic              ce        = 1'b1;
   logic              key_load  = 1'b0;
   logic              data_load = 1'b0;
   logic              start     = 1'b0;
   tdc_keys_t         keys_in   = '0;
   logic [BLK_W-1:0]  data_in   = '0;
   tdc_mode_t         mode_in   = '0;
   logic              busy;
   logic              done;
   logic [BLK_W-1:0]  result;
   int                failures    = 0;
   int                comparisons = 0;
   int                cycles      = 0;
   int                cyc;

   tdc_triple_cipher dut_u (
      .ref_clk   (ref_clk),
      .resetn    (resetn),
      .ce        (ce),
      .key_load  (key_load),
      .keys_in   (keys_in),
      .data_load (data_load),
      .data_in   (data_in),
      .start     (start),
      .mode_in   (mode_in),
      .busy      (busy),
      .done      (done),
      .result    (result)
   );

   always #50 ref_clk = ~ref_clk;

   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   // a hang past the expected run length is scored as a mismatch
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic check_eq(input logic [63:0] seen, input logic [63:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check_eq

   // stall > 0 freezes the clock enable and throws loads and a start in while busy
   task automatic run(input tdc_keys_t k, input logic [1:0] m, input logic [63:0] d,
                      input logic load, input int stall, output int n);
      @(posedge ref_clk);
      #1;
      key_load  = load;
      data_load = load;
      keys_in   = k;
      data_in   = d;
      @(posedge ref_clk);
      #1;
      key_load  = 1'b0;
      data_load = 1'b0;
      start     = 1'b1;
      mode_in   = tdc_mode_t'(m);
      @(posedge ref_clk);
      #1;
      start = 1'b0;
      n     = 0;
      check_eq(busy, 1, "busy after start");
      check_eq(done, 0, "done after start");
      while (done !== 1'b1 && n < 200)
      begin
         @(posedge ref_clk);
         #1;
         n++;
         if (stall != 0 && n == 10) ce = 1'b0;
         if (stall != 0 && n == 10 + stall) ce = 1'b1;
         if (stall != 0 && n == 20)
         begin
            start     = 1'b1;
            key_load  = 1'b1;
            data_load = 1'b1;
            keys_in   = ~k;
            data_in   = ~d;
         end
         if (stall != 0 && n == 21)
         begin
            start     = 1'b0;
            key_load  = 1'b0;
            data_load = 1'b0;
         end
      end
      check_eq(busy, 0, "busy at completion");
   endtask : run

   initial
   begin
      repeat (16) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      check_eq(busy, 0, "busy out of reset");
      check_eq(done, 0, "done out of reset");
      check_eq(result, 0, "result out of reset");
      foreach (rows[i])
      begin
         run(rows[i].k, rows[i].m, rows[i].d, 1'b1, 0, cyc);
         check_eq(result, rows[i].exp, "row result");
         check_eq(64'(cyc), 64'(CALC_CYCLES), "row latency");
      end
      // frozen enable stretches the run; loads and start while busy change nothing
      run(rows[0].k, 2'h0, PT, 1'b1, 4, cyc);
      check_eq(result, CT, "stalled result");
      check_eq(64'(cyc), 64'(CALC_CYCLES + 4), "stalled latency");
      run('0, 2'h0, 64'h0000_0000_0000_0000, 1'b0, 0, cyc);
      check_eq(result, CT, "busy loads ignored");
      repeat (3) @(posedge ref_clk);
      #1;
      check_eq(done, 1, "done sticky");
      check_eq(result, CT, "result held");
      // reset in mid-calculation
      start = 1'b1;
      @(posedge ref_clk);
      #1;
      start = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1;
      resetn = 1'b0;
      #1;
      check_eq(busy, 0, "busy in reset");
      check_eq(done, 0, "done in reset");
      check_eq(result, 0, "result in reset");
      @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      run(rows[1].k, rows[1].m, rows[1].d, 1'b1, 0, cyc);
      check_eq(result, PT, "after reset");
      tally_and_finish();
   end

endmodule : tb
`default_nettype wire
